// ==== adc_ctrl_pkg.sv ====
// Purpose: Shared constants for the converter control and result logic
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Register fields are 8 bits wide and sit in the low byte
package adc_ctrl_pkg;
    // Register byte offsets
    localparam int APB_ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL0 = 8'h00;
    localparam logic [7:0] OFF_CTRL1 = 8'h04;
    localparam logic [7:0] OFF_RES_HI = 8'h08;
    localparam logic [7:0] OFF_RES_LO = 8'h0C;
    localparam logic [7:0] OFF_PFLAG = 8'h10;
    localparam logic [7:0] OFF_PEN = 8'h14;
    localparam logic [7:0] OFF_INTCTL = 8'h18;
    // Control register zero fields
    localparam int CTRL0_EN = 0;
    localparam int CTRL0_GO = 1;
    localparam int CHS_LSB = 2;
    localparam int CHS_W = 5;
    // Control register one fields
    localparam int PREF_LSB = 0;
    localparam int CKS_LSB = 4;
    localparam int CKS_W = 3;
    localparam int CTRL1_JUST = 7;
    // Flag, enable and interrupt control bit positions
    localparam int DONE_BIT = 6;
    localparam int IRQEN_BIT = 6;
    localparam int GIE_BIT = 7;
    localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
    // Result layout
    localparam int RES_BITS = 10;
    localparam int IDX_W = 4;
    localparam int HI_SPLIT = 2;
    // Channel codes with special meaning
    localparam logic [4:0] CH_FIXED_REF = 5'h1F;
    localparam logic [4:0] CH_TEMP = 5'h1D;
    localparam logic [4:0] CH_VREF_NEG = 5'h1B;
    localparam logic [4:0] CH_VREF_POS = 5'h1A;
    localparam logic [4:0] CH_AN8 = 5'h08;
    localparam logic [4:0] CH_AN_MAX = 5'h13;
    // Low-range codes with no input behind them
    localparam logic [4:0] CH_RSVD_LO = 5'h05;
    localparam logic [4:0] CH_RSVD_HI = 5'h07;
    // Positive reference codes
    localparam logic [1:0] PREF_SUPPLY = 2'h0;
    localparam logic [1:0] PREF_RSVD = 2'h1;
    localparam logic [1:0] PREF_PIN = 2'h2;
    localparam logic [1:0] PREF_FIXED = 2'h3;
    // Conversion clock codes and divide ratios
    localparam logic [2:0] CKS_DIV2 = 3'h0;
    localparam logic [2:0] CKS_DIV8 = 3'h1;
    localparam logic [2:0] CKS_DIV32 = 3'h2;
    localparam logic [2:0] CKS_DIV4 = 3'h4;
    localparam logic [2:0] CKS_DIV16 = 3'h5;
    localparam logic [2:0] CKS_DIV64 = 3'h6;
    localparam logic [1:0] CKS_RC_LOW = 2'h3;
    localparam int DIV_W = 6;
    // Converter sequencer states
    typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_CONVERT} sar_state_e;
endpackage : adc_ctrl_pkg

// ==== conv_clock_tick.sv ====
// Purpose: Conversion clock tick from a divided core clock or the RC pin
// Assumes: RC oscillator level arrives asynchronously on a pin
// Notes: Tick is a one-cycle pulse per conversion clock period
`timescale 1ns/1ps
`default_nettype none
module conv_clock_tick #(
    parameter int DIV_A = 2,
    parameter int DIV_B = 4,
    parameter int DIV_C = 8
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [adc_ctrl_pkg::CKS_W-1:0] clock_select,
    input wire logic rc_osc_in,
    output logic tick
);
    import adc_ctrl_pkg::*;
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] limit;
    logic rc_s1_q, rc_s2_q, rc_s3_q, rc_filt_q, rc_prev_q;
    logic use_rc;

    ////////////////////////////////////////////////////////////////////////
    // Divide ratio lookup; both x11 codes pick the RC clock
    always_comb begin
        use_rc = (clock_select[1:0] == CKS_RC_LOW);
        unique case (clock_select)
            CKS_DIV2: limit = DIV_W'(DIV_A - 1);
            CKS_DIV4: limit = DIV_W'(DIV_B - 1);
            CKS_DIV8: limit = DIV_W'(DIV_C - 1);
            CKS_DIV16: limit = DIV_W'(15);
            CKS_DIV32: limit = DIV_W'(31);
            CKS_DIV64: limit = DIV_W'(63);
            default: limit = '0;
        endcase
    end

    // Core clock divider
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (use_rc || cnt_q >= limit) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + DIV_W'(1);
        end
    end

    // RC pin synchroniser with agreement filter
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rc_s1_q <= 1'b0;
            rc_s2_q <= 1'b0;
            rc_s3_q <= 1'b0;
            rc_filt_q <= 1'b0;
            rc_prev_q <= 1'b0;
        end else begin
            rc_s1_q <= rc_osc_in;
            rc_s2_q <= rc_s1_q;
            rc_s3_q <= rc_s2_q;
            if (rc_s2_q == rc_s3_q) begin
                rc_filt_q <= rc_s3_q;
            end
            rc_prev_q <= rc_filt_q;
        end
    end

    // Tick on divider wrap or RC rising edge
    assign tick = use_rc ? (rc_filt_q & ~rc_prev_q) : (cnt_q >= limit);
endmodule : conv_clock_tick
`default_nettype wire

// ==== sar_engine.sv ====
// Purpose: Successive-approximation sequencer
// Assumes: Comparator input already synchronised and filtered
// Notes: Abort yields a partial result filled with the last decided bit
`timescale 1ns/1ps
`default_nettype none
module sar_engine #(
    parameter int N = 10
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic stop,
    input wire logic tick,
    input wire logic comp_hi,
    output logic busy,
    output logic done,
    output logic load,
    output logic [N-1:0] result,
    output logic [N-1:0] trial,
    output logic hold_sample
);
    import adc_ctrl_pkg::*;
    sar_state_e state_q;
    logic [N-1:0] code_q;
    logic [IDX_W-1:0] idx_q;
    logic last_q;

    // Bits at and below the current index copy the last decided bit
    function automatic logic [N-1:0] fill_partial(input logic [N-1:0] c,
        input logic [IDX_W-1:0] i, input logic b);
        logic [N-1:0] f;
        f = '0;
        for (int k = 0; k < N; k++) begin
            f[k] = (k > int'(i)) ? c[k] : b;
        end
        return f;
    endfunction : fill_partial

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: sample one tick, then decide one bit per tick
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= SAR_IDLE;
            code_q <= '0;
            idx_q <= '0;
            last_q <= 1'b0;
            result <= '0;
            done <= 1'b0;
            load <= 1'b0;
        end else begin
            done <= 1'b0;
            load <= 1'b0;
            unique case (state_q)
                SAR_IDLE: begin
                    if (start) begin
                        state_q <= SAR_SAMPLE;
                        code_q <= '0;
                        idx_q <= IDX_W'(N - 1);
                        last_q <= 1'b0;
                    end
                end
                SAR_SAMPLE, SAR_CONVERT: begin
                    if (stop) begin
                        result <= fill_partial(code_q, idx_q, last_q);
                        load <= 1'b1;
                        state_q <= SAR_IDLE;
                    end else if (tick && state_q == SAR_SAMPLE) begin
                        state_q <= SAR_CONVERT;
                    end else if (tick) begin
                        code_q[idx_q] <= comp_hi;
                        last_q <= comp_hi;
                        if (idx_q == '0) begin
                            result <= code_q | N'(comp_hi);
                            load <= 1'b1;
                            done <= 1'b1;
                            state_q <= SAR_IDLE;
                        end else begin
                            idx_q <= idx_q - IDX_W'(1);
                        end
                    end
                end
            endcase
        end
    end

    // Trial code for the DAC and hold switch control
    assign busy = (state_q != SAR_IDLE);
    assign trial = (state_q == SAR_CONVERT) ? (code_q | (N'(1) << idx_q)) : '0;
    // Hold tracks the input except while converting; never discharged
    assign hold_sample = (state_q != SAR_CONVERT);
endmodule : sar_engine
`default_nettype wire

// ==== adc_control_result_regs.sv ====
// Purpose: APB control and result registers of a 10-bit SAR converter
// Assumes: Zero-wait APB slave; comparator and RC clock arrive on pins
// Notes: Hold capacitor charge carries over between conversions
// Notes on behaviour
// - Writing go starts a conversion only if enable was already set; go reads one until it finishes
// - Enable bit powers the converter; clearing it halts a conversion
// - Justify bit one means right, zero means left; unused bits zero
// - Clock codes 011 and 111 select the RC oscillator, others divide core clock
// - Reference code 00 supply, 10 pin, 11 fixed reference, 01 reserved
// - Left: high byte bits 9..2, low byte top two bits hold bits 1..0
// - Right: high byte low two bits hold 9..8, low byte bits 7..0
// - Hold capacitor is never discharged between conversions
// - Done flag and its enable at bit 6; global, peripheral at 7 and 6
// - Completion clears go, sets done flag and loads result bytes
// - Clearing go aborts; result takes partial value, last bit filled
// - Codes 101, 010, 110 divide by 16, 32, 64; x11 picks RC
// - Done flag sets on every completed conversion and stays until cleared
`timescale 1ns/1ps
`default_nettype none
module adc_control_result_regs #(
    parameter int DIV_A = 2,
    parameter int DIV_B = 4,
    parameter int DIV_C = 8
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [adc_ctrl_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comp_in,
    input wire logic rc_osc_in,
    output logic [adc_ctrl_pkg::CHS_W-1:0] mux_channel,
    output logic mux_connect,
    output logic [1:0] ref_select,
    output logic converter_on,
    output logic rc_osc_enable,
    output logic [adc_ctrl_pkg::RES_BITS-1:0] dac_trial,
    output logic hold_sample,
    output logic conversion_busy
);
    import adc_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [CHS_W-1:0] chs_q;
    logic go_q, en_q, just_q;
    logic [CKS_W-1:0] cks_q;
    logic [1:0] pref_q;
    logic [7:0] res_hi_q, res_lo_q;
    logic done_flag_q, irq_en_q, gie_q, peripheral_irq_enable_q;
    logic connect_q;
    logic [31:0] prdata_q;
    logic cmp_s1_q, cmp_s2_q, cmp_s3_q, cmp_filt_q;
    logic setup, access, wr, hit;
    logic wr_ctrl0, wr_ctrl1, wr_hi, wr_lo, wr_flag, wr_pen, wr_int;
    logic start, stop, tick, eng_busy, eng_done, eng_load;
    logic [RES_BITS-1:0] eng_result;
    logic [7:0] rd_byte;

    // Channel codes that connect something
    function automatic logic chan_ok(input logic [CHS_W-1:0] c);
        return ((c <= CH_AN_MAX) && !((c >= CH_RSVD_LO) && (c <= CH_RSVD_HI)))
            || (c == CH_FIXED_REF) || (c == CH_TEMP)
            || (c == CH_VREF_NEG) || (c == CH_VREF_POS);
    endfunction : chan_ok

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign hit = (paddr == OFF_CTRL0) || (paddr == OFF_CTRL1)
        || (paddr == OFF_RES_HI) || (paddr == OFF_RES_LO)
        || (paddr == OFF_PFLAG) || (paddr == OFF_PEN)
        || (paddr == OFF_INTCTL);
    assign wr_ctrl0 = wr & (paddr == OFF_CTRL0);
    assign wr_ctrl1 = wr & (paddr == OFF_CTRL1);
    assign wr_hi = wr & (paddr == OFF_RES_HI);
    assign wr_lo = wr & (paddr == OFF_RES_LO);
    assign wr_flag = wr & (paddr == OFF_PFLAG);
    assign wr_pen = wr & (paddr == OFF_PEN);
    assign wr_int = wr & (paddr == OFF_INTCTL);
    assign pready = 1'b1;
    assign pslverr = access & ~hit;
    assign prdata = prdata_q;

    // Read mux; unimplemented bits read zero
    always_comb begin
        rd_byte = '0;
        unique case (paddr)
            OFF_CTRL0: begin
                rd_byte[CHS_LSB +: CHS_W] = chs_q;
                rd_byte[CTRL0_GO] = go_q;
                rd_byte[CTRL0_EN] = en_q;
            end
            OFF_CTRL1: begin
                rd_byte[CTRL1_JUST] = just_q;
                rd_byte[CKS_LSB +: CKS_W] = cks_q;
                rd_byte[PREF_LSB +: 2] = pref_q;
            end
            OFF_RES_HI: rd_byte = res_hi_q;
            OFF_RES_LO: rd_byte = res_lo_q;
            OFF_PFLAG: rd_byte[DONE_BIT] = done_flag_q;
            OFF_PEN: rd_byte[IRQEN_BIT] = irq_en_q;
            OFF_INTCTL: begin
                rd_byte[GIE_BIT] = gie_q;
                rd_byte[PERIPHERAL_IRQ_ENABLE_BIT] = peripheral_irq_enable_q;
            end
            default: rd_byte = '0;
        endcase
    end

    // Read data captured in the setup cycle, held through access
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_q <= '0;
        end else if (setup) begin
            prdata_q <= (pwrite || !hit) ? '0 : 32'(rd_byte);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparator pin synchroniser with agreement filter
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
            cmp_s3_q <= 1'b0;
            cmp_filt_q <= 1'b0;
        end else begin
            cmp_s1_q <= comp_in;
            cmp_s2_q <= cmp_s1_q;
            cmp_s3_q <= cmp_s2_q;
            if (cmp_s2_q == cmp_s3_q) begin
                cmp_filt_q <= cmp_s3_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start needs the converter already on; abort on go clear or disable
    // A write that sets go but clears enable must not start anything
    assign start = wr_ctrl0 & pwdata[CTRL0_GO] & pwdata[CTRL0_EN]
        & en_q & ~go_q;
    assign stop = go_q & ((wr_ctrl0 & ~pwdata[CTRL0_GO])
        | (wr_ctrl0 & ~pwdata[CTRL0_EN]));

    // Control register zero; bit 7 is never stored
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chs_q <= '0;
            en_q <= 1'b0;
            connect_q <= 1'b0;
        end else if (wr_ctrl0) begin
            chs_q <= pwdata[CHS_LSB +: CHS_W];
            en_q <= pwdata[CTRL0_EN];
            connect_q <= chan_ok(pwdata[CHS_LSB +: CHS_W]);
        end
    end

    // Go flag: hardware clears on completion, software may clear
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            go_q <= 1'b0;
        end else if (eng_done || stop) begin
            go_q <= 1'b0;
        end else if (start) begin
            go_q <= 1'b1;
        end
    end

    // Control register one; bits 3..2 are never stored
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            just_q <= 1'b0;
            cks_q <= '0;
            pref_q <= PREF_SUPPLY;
        end else if (wr_ctrl1) begin
            just_q <= pwdata[CTRL1_JUST];
            cks_q <= pwdata[CKS_LSB +: CKS_W];
            pref_q <= pwdata[PREF_LSB +: 2];
        end
    end

    // Result bytes: engine load formats by current justify bit
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            res_hi_q <= '0;
            res_lo_q <= '0;
        end else if (eng_load) begin
            if (just_q) begin
                res_hi_q <= {6'h00, eng_result[RES_BITS-1 -: HI_SPLIT]};
                res_lo_q <= eng_result[7:0];
            end else begin
                res_hi_q <= eng_result[RES_BITS-1 -: 8];
                res_lo_q <= {eng_result[HI_SPLIT-1:0], 6'h00};
            end
        end else begin
            if (wr_hi) begin
                res_hi_q <= pwdata[7:0];
            end
            if (wr_lo) begin
                res_lo_q <= pwdata[7:0];
            end
        end
    end

    // Done flag: set wins over a software clear in the same cycle
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            done_flag_q <= 1'b0;
        end else if (eng_done) begin
            done_flag_q <= 1'b1;
        end else if (wr_flag) begin
            done_flag_q <= pwdata[DONE_BIT];
        end
    end

    // Interrupt enable bits
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_en_q <= 1'b0;
            gie_q <= 1'b0;
            peripheral_irq_enable_q <= 1'b0;
        end else begin
            if (wr_pen) begin
                irq_en_q <= pwdata[IRQEN_BIT];
            end
            if (wr_int) begin
                gie_q <= pwdata[GIE_BIT];
                peripheral_irq_enable_q <= pwdata[PERIPHERAL_IRQ_ENABLE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion clock and sequencer
    conv_clock_tick #(
        .DIV_A(DIV_A),
        .DIV_B(DIV_B),
        .DIV_C(DIV_C)
    ) u_tick (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clock_select(cks_q),
        .rc_osc_in(rc_osc_in),
        .tick(tick)
    );

    sar_engine #(
        .N(RES_BITS)
    ) u_sar (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .start(start),
        .stop(stop),
        .tick(tick),
        .comp_hi(cmp_filt_q),
        .busy(eng_busy),
        .done(eng_done),
        .load(eng_load),
        .result(eng_result),
        .trial(dac_trial),
        .hold_sample(hold_sample)
    );

    // Analog side controls
    assign mux_channel = chs_q;
    assign mux_connect = connect_q;
    assign ref_select = pref_q;
    assign converter_on = en_q;
    assign rc_osc_enable = (cks_q[1:0] == CKS_RC_LOW);
    assign conversion_busy = eng_busy;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    go_start_a: assert property (start |=> go_q && eng_busy)
        else $error("go flag did not rise on start");
    go_clear_a: assert property (eng_done |=> !go_q)
        else $error("go flag stayed set after completion");
    done_set_a: assert property (eng_done |=> done_flag_q)
        else $error("done flag missed a completion");
    flag_hold_a: assert property (done_flag_q && !wr_flag |=> done_flag_q)
        else $error("done flag dropped without a clear");
    abort_load_a: assert property (stop |=> eng_load ##1 !eng_busy)
        else $error("abort did not load a partial result");
    left_zero_a: assert property (eng_load && !just_q
        |=> res_lo_q[5:0] == 6'h00 && res_hi_q == $past(eng_result[9:2]))
        else $error("left justified layout wrong");
    right_zero_a: assert property (eng_load && just_q
        |=> res_hi_q[7:2] == 6'h00 && res_lo_q == $past(eng_result[7:0]))
        else $error("right justified layout wrong");
    ctrl0_bit7_a: assert property (setup && !pwrite && paddr == OFF_CTRL0
        |=> !prdata[7])
        else $error("control zero bit 7 read as one");
    ctrl1_gap_a: assert property (setup && !pwrite && paddr == OFF_CTRL1
        |=> prdata[3:2] == 2'h0)
        else $error("control one bits 3..2 read as one");
    no_start_off_a: assert property (!en_q |-> !go_q && !eng_busy)
        else $error("converter ran while disabled");
    reserved_mux_a: assert property (wr_ctrl0
        && pwdata[CHS_LSB +: CHS_W] == 5'h1E |=> !mux_connect)
        else $error("reserved channel connected");
    rc_pick_a: assert property (cks_q == 3'h3 |-> rc_osc_enable)
        else $error("RC clock not selected for code 011");
    hold_conv_a: assert property (eng_busy && !hold_sample
        |-> go_q || $past(stop))
        else $error("hold switch open outside a conversion");

    full_conv_c: cover property (start ##[1:800] eng_done);
    abort_c: cover property (go_q ##1 stop);
    set_clear_c: cover property (eng_done && wr_flag);
endmodule : adc_control_result_regs
`default_nettype wire

// ==== adc_control_result_regs_bench.sv ====
// Purpose: Self-checking bench for the converter control and result block
// Assumes: Zero-wait APB slave; comparator pin held steady per conversion
// Notes: RC pin toggles every four core cycles
`timescale 1ns/1ps
`default_nettype none
module adc_control_result_regs_bench;
    import adc_ctrl_pkg::*;
    logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, serr, comp_in = 0, rc_osc_in = 0, mux_connect;
    logic converter_on, rc_osc_enable, hold_sample, conversion_busy;
    logic [4:0] mux_channel;
    logic [1:0] ref_select;
    logic [9:0] dac_trial;
    int errors = 0, tests_run = 0, cycles = 0;
    // Settling wait software owes before go; value is a plain choice
    localparam int ACQ_CYCLES = 16;
    adc_control_result_regs uut (.core_clk(core_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comp_in(comp_in), .rc_osc_in(rc_osc_in),
        .mux_channel(mux_channel), .mux_connect(mux_connect),
        .ref_select(ref_select), .converter_on(converter_on),
        .rc_osc_enable(rc_osc_enable), .dac_trial(dac_trial),
        .hold_sample(hold_sample), .conversion_busy(conversion_busy));
    ////////////////////////////////////////////////////////////////////
    // Clock, RC pin and hang guard
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        rc_osc_in <= cycles[2];
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic close_out();
        if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    // Value comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 0;
        penable <= 0;
        // Let the written state settle before anything is checked
        @(negedge core_clk);
    endtask : apb
    ////////////////////////////////////////////////////////////////////
    // Field layout, reserved bits, channel routing and reference codes
    task automatic t_fields();
        logic [4:0] ch[7] = '{5'h1F, 5'h1E, 5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h07};
        logic con[7] = '{1, 0, 1, 0, 1, 1, 0};
        apb(0, OFF_CTRL0, 0); chk(rd, 32'h0000_0000);
        apb(0, OFF_CTRL1, 0); chk(rd, 32'h0000_0000);
        apb(1, OFF_CTRL0, 32'h0000_00FF);
        apb(0, OFF_CTRL0, 0); chk(rd, 32'h0000_007D);
        chk(converter_on, 1);
        for (int i = 0; i < 7; i++) begin
            apb(1, OFF_CTRL0, {25'h0, ch[i], 2'b00});
            chk(mux_channel, ch[i]);
            chk(mux_connect, con[i]);
        end
        chk(converter_on, 0);
        apb(1, OFF_CTRL1, 32'h0000_00FF);
        apb(0, OFF_CTRL1, 0); chk(rd, 32'h0000_00F3);
        chk(rc_osc_enable, 1);
        for (int i = 0; i < 4; i++) begin
            apb(1, OFF_CTRL1, i);
            chk(ref_select, i[1:0]);
        end
        apb(1, 8'h1C, 32'h0000_00FF); chk(serr, 1);
        apb(0, 8'h1C, 0); chk(rd, 32'h0000_0000);
    endtask : t_fields
    ////////////////////////////////////////////////////////////////////
    // Start a conversion; abort once bit 9 is decided if asked
    task automatic t_conv(input logic [7:0] c1, input logic cmp,
                          input logic abort, input logic [7:0] hi,
                          input logic [7:0] lo);
        int n = 0;
        @(posedge core_clk);
        comp_in <= cmp;
        apb(1, OFF_PFLAG, 0);
        apb(1, OFF_CTRL1, c1);
        apb(1, OFF_CTRL0, 32'h0000_0001);
        repeat (ACQ_CYCLES) @(posedge core_clk);
        apb(1, OFF_CTRL0, 32'h0000_0003);
        if (abort) begin
            while (dac_trial[8] !== 1'b1 && n < 2000) begin
                @(posedge core_clk);
                n++;
            end
            chk(dac_trial, 32'h0000_0300);
            chk(hold_sample, 0);
            apb(1, OFF_CTRL0, 32'h0000_0001);
        end
        do begin
            apb(0, OFF_CTRL0, 0);
            n++;
        end while (rd[1] !== 1'b0 && n < 3000);
        chk(rd, 32'h0000_0001);
        chk(conversion_busy, 0);
        chk(hold_sample, 1);
        apb(0, OFF_RES_HI, 0); chk(rd, {24'h0, hi});
        apb(0, OFF_RES_LO, 0); chk(rd, {24'h0, lo});
        apb(0, OFF_PFLAG, 0); chk(rd, abort ? 32'h0 : 32'h0000_0040);
    endtask : t_conv
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 0;
        t_fields();
        t_conv(8'h80, 1, 0, 8'h03, 8'hFF);
        apb(1, OFF_CTRL1, 32'h0000_0000);
        apb(0, OFF_RES_HI, 0); chk(rd, 32'h0000_0003);
        t_conv(8'h50, 1, 0, 8'hFF, 8'hC0);
        t_conv(8'hE0, 1, 1, 8'h03, 8'hFF);
        t_conv(8'hB0, 0, 0, 8'h00, 8'h00);
        apb(1, OFF_PFLAG, 0);
        apb(0, OFF_PFLAG, 0); chk(rd, 32'h0000_0000);
        close_out();
    end
endmodule : adc_control_result_regs_bench
`default_nettype wire
